// ### hw/ptxf_top.sv
/*
  Transmit stream flow control: takes packets from the user stream, throttles
  the source, discards, poisons, appends digests and forwards beats to the link.
  Assumes the user stream and the link stage run on pclk and that the link
  stage patches EP into a stored header when set_ep marks the last data beat.
*/
// The implementer's own choice: the APB interface to the registers.
module ptxf_top
  import ptxf_pkg::*;
(
  input wire logic pclk, // User clock, 20 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped offsets.
  input wire ptxf_axis_t s_axis_tx, // User transmit stream.
  output logic s_axis_tx_tready, // Transmit ready.
  output logic tx_err_drop, // Packet discarded pulse.
  output logic tx_cfg_req, // Internal packet pending.
  input wire logic tx_cfg_gnt, // User grants the datapath.
  input wire logic cfg_tlp_pend, // Core has an internal packet waiting.
  output logic cfg_tlp_done, // Internal packet slot finished pulse.
  output ptxf_lnk_t lnk, // Beats toward the link.
  input wire logic lnk_slot_free // Link released one buffer slot.
);

  typedef struct packed {
    ptxf_state_t state;
    logic ready;
    logic str;
    logic ecrc;
    logic fwd;
    logic bad;
    logic thr;
    logic gnt_seen;
    logic [2:0] cfg_cnt;
    logic [31:0] crc;
    logic drop;
    logic cfg_req;
    logic cfg_done;
    ptxf_lnk_t lnk;
    logic [15:0] devctl;
    logic [1:0] ps;
    logic link_up;
    logic [7:0] drop_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ptxf_regs_t;

  ptxf_regs_t s_r;
  ptxf_regs_t s_nxt;
  logic [PTXF_SLOT_W-1:0] slot_cnt;
  logic acc;
  logic first;
  logic dsc;
  logic eof;
  logic cur_str;
  logic cur_ecrc;
  logic cur_fwd;
  logic cur_bad;
  logic oversize;
  logic non_d0;
  logic buf_block;
  logic block;
  logic [10:0] len_dw;
  logic [10:0] mps_dw;
  logic [127:0] beat;

  // Serial digest update over the bytes that keep marks valid.
  function automatic logic [31:0] ptxf_crc(input logic [31:0] c_in, input logic [127:0] d,
                                           input logic [15:0] k);
    logic [31:0] c;
    logic fb;
    c = c_in;
    for (int i = 0; i < 128; i++) begin
      fb = c[31] ^ d[i];
      if (k[i/8]) begin
        c = {c[30:0], 1'b0} ^ (fb ? PTXF_CRC_POLY : 32'h0000_0000);
      end
    end
    return c;
  endfunction : ptxf_crc

  ptxf_slot_cnt u_slot (
    .pclk(pclk),
    .presetn(presetn),
    .take(first),
    .free(lnk_slot_free),
    .count_r(slot_cnt)
  );

  // Beat qualification and packet flags that combine the stored state with the beat.
  always_comb begin
    acc = s_axis_tx.tvalid && s_r.ready; // RULE_01
    first = acc && (s_r.state != PTXF_PKT);
    dsc = acc && (s_r.state == PTXF_PKT) && s_axis_tx.tuser[PTXF_U_DSC]; // RULE_08 RULE_10
    eof = acc && (s_axis_tx.tlast || dsc);
    len_dw = {1'b0, s_axis_tx.tdata[PTXF_H_LEN_LSB +: PTXF_H_LEN_W]};
    if (len_dw == 11'h000) begin
      len_dw = PTXF_LEN_ZERO_DW;
    end
    mps_dw = PTXF_MPS_BASE_DW << PTXF_DEVCAP_RST[PTXF_MPS_LSB +: PTXF_MPS_W];
    oversize = s_axis_tx.tdata[PTXF_H_HASDATA] && (len_dw > mps_dw); // RULE_12
    cur_str = first ? s_axis_tx.tuser[PTXF_U_STR] : s_r.str;
    cur_ecrc = first ? (s_axis_tx.tuser[PTXF_U_ECRC] && !s_axis_tx.tdata[PTXF_H_TD]) : s_r.ecrc; // RULE_20
    cur_fwd = (first ? 1'b0 : s_r.fwd) | s_axis_tx.tuser[PTXF_U_FWD]; // RULE_15
    cur_bad = (first ? 1'b0 : s_r.bad) | !s_r.link_up | (first && oversize) | (!first && s_r.thr); // RULE_12
    non_d0 = s_r.ps != PTXF_PS_D0;
    buf_block = (slot_cnt == PTXF_SLOTS) || (first && slot_cnt == PTXF_SLOTS - 1'b1);
    block = buf_block || non_d0 || s_r.gnt_seen || (tx_cfg_gnt && cfg_tlp_pend); // RULE_02 RULE_06
    beat = s_axis_tx.tdata;
    if (first && cur_ecrc) begin
      beat[PTXF_H_TD] = 1'b1;
    end
    if (first && cur_fwd && !cur_str) begin
      beat[PTXF_H_EP] = 1'b1;
    end
  end

  // Next state of the stream machine and of the register file.
  always_comb begin
    s_nxt = s_r;
    s_nxt.drop = 1'b0;
    s_nxt.cfg_done = 1'b0;
    s_nxt.lnk = '0;
    // A grant that overlaps the internal packet or its done pulse belongs to that packet, not to the next one.
    s_nxt.gnt_seen = s_r.gnt_seen | (tx_cfg_gnt && cfg_tlp_pend && s_r.state != PTXF_CFG && !s_r.cfg_done);
    s_nxt.cfg_req = cfg_tlp_pend && (s_r.state != PTXF_CFG) && !s_r.cfg_done; // RULE_23
    case (s_r.state)
      PTXF_IDLE, PTXF_PKT: begin
        if (s_r.state == PTXF_PKT && !s_axis_tx.tvalid && s_r.str) begin
          s_nxt.thr = 1'b1; // RULE_18
        end
        if (acc) begin
          s_nxt.str = cur_str;
          s_nxt.ecrc = cur_ecrc;
          s_nxt.fwd = cur_fwd;
          s_nxt.bad = cur_bad;
          s_nxt.thr = first ? 1'b0 : s_r.thr;
          s_nxt.crc = ptxf_crc(first ? PTXF_CRC_INIT : s_r.crc, beat, s_axis_tx.tkeep);
          s_nxt.lnk.valid = 1'b1;
          s_nxt.lnk.data = beat;
          s_nxt.lnk.keep = s_axis_tx.tkeep;
        end
        if (eof) begin
          s_nxt.str = 1'b0;
          s_nxt.thr = 1'b0;
          s_nxt.lnk.nullify = cur_str && (dsc || cur_bad); // RULE_11 RULE_18
          s_nxt.lnk.discard = !cur_str && (dsc || cur_bad); // RULE_11 RULE_12
          s_nxt.lnk.set_ep = cur_fwd && !cur_str; // RULE_15
          s_nxt.drop = cur_bad; // RULE_13 RULE_25
          if (cur_bad) begin
            s_nxt.drop_cnt = s_r.drop_cnt + 8'h01;
          end
          if (cur_ecrc && !dsc && !cur_bad) begin
            s_nxt.state = PTXF_DIGEST;
            s_nxt.ready = 1'b0; // RULE_21
          end else begin
            s_nxt.lnk.last = 1'b1;
            s_nxt.state = PTXF_IDLE;
            s_nxt.ready = !block; // RULE_02 RULE_03
          end
        end else if (acc || s_r.state == PTXF_PKT) begin
          s_nxt.state = PTXF_PKT;
          s_nxt.ready = 1'b1; // RULE_04
        end else if (s_r.gnt_seen && cfg_tlp_pend) begin
          s_nxt.state = PTXF_CFG;
          s_nxt.ready = 1'b0; // RULE_05
          s_nxt.gnt_seen = 1'b0;
          s_nxt.cfg_cnt = PTXF_CFG_CYCLES - 3'h1;
        end else begin
          s_nxt.gnt_seen = s_nxt.gnt_seen && cfg_tlp_pend; // RULE_23
          s_nxt.ready = !block; // RULE_06
        end
      end
      PTXF_DIGEST: begin
        s_nxt.lnk.valid = 1'b1;
        s_nxt.lnk.data = {96'h0, ~s_r.crc};
        s_nxt.lnk.keep = PTXF_KEEP_DW0;
        s_nxt.lnk.last = 1'b1;
        s_nxt.state = PTXF_IDLE;
        s_nxt.ready = !block; // RULE_21
      end
      PTXF_CFG: begin
        s_nxt.ready = 1'b0; // RULE_05
        if (s_r.cfg_cnt == 3'h0) begin
          s_nxt.state = PTXF_IDLE;
          s_nxt.cfg_done = 1'b1;
        end else begin
          s_nxt.cfg_cnt = s_r.cfg_cnt - 3'h1;
        end
      end
      default: begin
        s_nxt.state = PTXF_IDLE;
        s_nxt.ready = 1'b0;
      end
    endcase
    // APB slave: answer in the first access cycle, write at the completing edge.
    s_nxt.pready = psel && !penable && !s_r.pready;
    if (psel && !penable) begin
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      if (paddr == PTXF_OFS_DEVCAP) begin
        s_nxt.prdata = PTXF_DEVCAP_RST;
      end else if (paddr == PTXF_OFS_DEVCTL) begin
        s_nxt.prdata = {16'h0000, s_r.devctl};
      end else if (paddr == PTXF_OFS_POWER_MGMT_CONTROL_STATUS) begin
        s_nxt.prdata = {30'h0, s_r.ps};
      end else if (paddr == PTXF_OFS_CTRL) begin
        s_nxt.prdata = {31'h0, s_r.link_up};
      end else if (paddr == PTXF_OFS_STATUS) begin
        s_nxt.prdata[PTXF_ST_STATE_LSB +: 2] = s_r.state;
        s_nxt.prdata[PTXF_ST_ND0_BIT] = non_d0;
        s_nxt.prdata[PTXF_ST_SLOT_LSB +: PTXF_SLOT_W] = slot_cnt;
        s_nxt.prdata[PTXF_ST_DROP_LSB +: 8] = s_r.drop_cnt;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
      if (paddr == PTXF_OFS_DEVCTL) begin
        s_nxt.devctl = pwdata[15:0];
      end else if (paddr == PTXF_OFS_POWER_MGMT_CONTROL_STATUS) begin
        s_nxt.ps = pwdata[PTXF_PS_LSB +: 2];
      end else if (paddr == PTXF_OFS_CTRL) begin
        s_nxt.link_up = pwdata[PTXF_CTRL_LINK_BIT];
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.state <= PTXF_IDLE;
      s_r.devctl <= PTXF_DEVCTL_RST;
      s_r.ps <= PTXF_PS_D0;
      s_r.link_up <= PTXF_LINK_UP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign s_axis_tx_tready = s_r.ready;
  assign tx_err_drop = s_r.drop;
  assign tx_cfg_req = s_r.cfg_req;
  assign cfg_tlp_done = s_r.cfg_done;
  assign lnk = s_r.lnk;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

  // Checks of the flow control timing.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_hold_in_pkt;
    s_r.state == PTXF_PKT |-> s_axis_tx_tready;
  endproperty
  a_hold_in_pkt: assert property (p_hold_in_pkt) else $error("Ready fell inside a packet."); // RULE_04

  property p_full_throttle;
    (eof && buf_block && !s_r.ecrc) |=> !s_axis_tx_tready;
  endproperty
  a_full_throttle: assert property (p_full_throttle) else $error("No throttle after last beat."); // RULE_03

  property p_cfg_low;
    s_r.state == PTXF_CFG |-> !s_axis_tx_tready;
  endproperty
  a_cfg_low: assert property (p_cfg_low) else $error("Ready high during internal packet."); // RULE_05

  property p_non_d0;
    (s_r.state == PTXF_IDLE && non_d0 && !first) |=> !s_axis_tx_tready;
  endproperty
  a_non_d0: assert property (p_non_d0) else $error("Ready high outside D0."); // RULE_06

  property p_idle_ignored;
    (!s_axis_tx.tvalid && s_r.state != PTXF_DIGEST) |=> !lnk.valid;
  endproperty
  a_idle_ignored: assert property (p_idle_ignored) else $error("Beat forwarded without valid."); // RULE_01

  property p_drop_pulse;
    (eof && cur_bad) |=> tx_err_drop ##1 ($past(eof && cur_bad) || !tx_err_drop);
  endproperty
  a_drop_pulse: assert property (p_drop_pulse) else $error("Drop pulse missing or stretched."); // RULE_13

  property p_digest_gap;
    s_r.state == PTXF_DIGEST |-> !s_axis_tx_tready ##1 (s_r.state == PTXF_IDLE && lnk.last);
  endproperty
  a_digest_gap: assert property (p_digest_gap) else $error("Digest gap not one cycle."); // RULE_21

  property p_stream_null;
    (eof && cur_str && (dsc || cur_bad)) |=> (lnk.nullify && !lnk.discard);
  endproperty
  a_stream_null: assert property (p_stream_null) else $error("Streamed abort not nullified."); // RULE_18

  property p_first_dsc;
    (first && !s_axis_tx.tlast) |=> s_r.state == PTXF_PKT;
  endproperty
  a_first_dsc: assert property (p_first_dsc) else $error("Discontinue acted outside a packet."); // RULE_10

  property p_poison;
    (eof && cur_fwd && !cur_str) |=> lnk.set_ep;
  endproperty
  a_poison: assert property (p_poison) else $error("Error forward not marked."); // RULE_15

endmodule : ptxf_top

// ### common/ptxf_pkg.sv
/*
  Shared constants, types and state encodings of the transmit stream flow
  control block.
  Assumes a single 20 MHz user clock and an APB master that owns the
  register window.
*/
// Function
// RULE_01 - Data bus is ignored on any cycle where valid is low.
// RULE_02 - Ready drops for a full buffer only after the current packet ends.
// RULE_03 - A back-to-back packet is throttled right after the previous last beat.
// RULE_04 - After the first beat is taken, every remaining beat is taken too.
// RULE_05 - Ready stays low while a granted internal packet is sent.
// RULE_06 - Outside D0, finish the current packet then hold ready low.
// RULE_07 - The source holds all stream signals stable while ready is low.
// RULE_08 - Discontinue counts only together with valid and ready.
// RULE_09 - The source never discontinues on a first beat; last is optional.
// RULE_10 - Discontinue outside a packet has no effect.
// RULE_11 - Discontinued packet: discard if not streamed, else end with EDB.
// RULE_12 - Discard on link down, oversize payload or a streamed valid gap.
// RULE_13 - Discarded packet is fully taken; drop shows within three clocks.
// RULE_14 - The source may set EP itself when poison is known early.
// RULE_15 - Error-forward on any taken beat sets EP in the header.
// RULE_16 - The source does not use error-forward on streamed packets.
// RULE_17 - Streamed packets keep stream set and valid high to the end.
// RULE_18 - A throttled streamed packet is dropped and nullified on the link.
// RULE_19 - Digest generation is requested on the first beat.
// RULE_20 - Without a digest, compute and append one and set TD.
// RULE_21 - Digest insertion drops ready for exactly one cycle.
// RULE_22 - The source keeps packets within the programmed payload size.
// RULE_23 - Pending internal packets raise request; the source grants promptly.
// RULE_24 - Packets start in the lowest dword; back-to-back start is allowed.
// RULE_25 - Drop is a one-cycle pulse per discarded packet.
package ptxf_pkg;

  // Register byte offsets.
  localparam logic [7:0] PTXF_OFS_DEVCAP = 8'h04;
  localparam logic [7:0] PTXF_OFS_DEVCTL = 8'h08;
  localparam logic [7:0] PTXF_OFS_POWER_MGMT_CONTROL_STATUS = 8'h0C;
  localparam logic [7:0] PTXF_OFS_CTRL = 8'h10;
  localparam logic [7:0] PTXF_OFS_STATUS = 8'h14;

  // Reset values.
  localparam logic [31:0] PTXF_DEVCAP_RST = 32'h0000_0001;
  localparam logic [15:0] PTXF_DEVCTL_RST = 16'h0000;
  localparam logic [1:0] PTXF_PS_D0 = 2'h0;
  localparam logic PTXF_LINK_UP_RST = 1'b1;

  // Field positions.
  localparam int PTXF_MPS_LSB = 0;
  localparam int PTXF_MPS_W = 3;
  localparam int PTXF_PS_LSB = 0;
  localparam int PTXF_CTRL_LINK_BIT = 0;
  localparam int PTXF_ST_STATE_LSB = 0;
  localparam int PTXF_ST_ND0_BIT = 3;
  localparam int PTXF_ST_SLOT_LSB = 4;
  localparam int PTXF_ST_DROP_LSB = 8;

  // Sideband bit positions.
  localparam int PTXF_U_ECRC = 0;
  localparam int PTXF_U_FWD = 1;
  localparam int PTXF_U_STR = 2;
  localparam int PTXF_U_DSC = 3;

  // Header dword 0 fields.
  localparam int PTXF_H_LEN_LSB = 0;
  localparam int PTXF_H_LEN_W = 10;
  localparam int PTXF_H_EP = 14;
  localparam int PTXF_H_TD = 15;
  localparam int PTXF_H_HASDATA = 30;
  localparam logic [10:0] PTXF_LEN_ZERO_DW = 11'h400;
  localparam logic [10:0] PTXF_MPS_BASE_DW = 11'h020;

  // Digest generator.
  localparam logic [31:0] PTXF_CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] PTXF_CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [15:0] PTXF_KEEP_DW0 = 16'h000F;

  // Internal packet and buffer pool sizing.
  localparam logic [2:0] PTXF_CFG_CYCLES = 3'h4;
  localparam int PTXF_SLOT_W = 3;
  localparam logic [PTXF_SLOT_W-1:0] PTXF_SLOTS = 3'h4;

  typedef enum logic [1:0] {
    PTXF_IDLE = 2'b00,
    PTXF_PKT = 2'b01,
    PTXF_DIGEST = 2'b11,
    PTXF_CFG = 2'b10
  } ptxf_state_t;

  typedef struct packed {
    logic tvalid;
    logic [127:0] tdata;
    logic [15:0] tkeep;
    logic tlast;
    logic [3:0] tuser;
  } ptxf_axis_t;

  typedef struct packed {
    logic valid;
    logic [127:0] data;
    logic [15:0] keep;
    logic last;
    logic nullify;
    logic discard;
    logic set_ep;
  } ptxf_lnk_t;

endpackage : ptxf_pkg

// ### hw/ptxf_slot_cnt.sv
/*
  Occupancy counter of the transmit buffer pool, counted in packets.
  Assumes take and free are single-cycle pulses on the user clock.
*/
module ptxf_slot_cnt
  import ptxf_pkg::*;
(
  input wire logic pclk, // User clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic take, // A packet enters the pool.
  input wire logic free, // The link has sent one packet.
  output logic [PTXF_SLOT_W-1:0] count_r // Packets held.
);

  logic [PTXF_SLOT_W-1:0] count_nxt;

  // Saturate at both ends so a stray free cannot wrap the count.
  always_comb begin
    count_nxt = count_r;
    if (take && !free && count_r != PTXF_SLOTS) begin
      count_nxt = count_r + 1'b1;
    end else if (free && !take && count_r != '0) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Count register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : ptxf_slot_cnt

// ### bench/ptxf_src_model.sv
/*
  User logic that issues packets on the transmit stream and grants internal packets.
  Assumes tasks are called just after a rising edge of pclk.
*/
module ptxf_src_model
  import ptxf_pkg::*;
(
  input wire logic pclk, // User clock.
  input wire logic tready, // Transmit ready from the block.
  input wire logic cfg_req, // Internal packet pending.
  output ptxf_axis_t s_axis, // Transmit stream toward the block.
  output logic cfg_gnt // Datapath grant.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet stream at time zero; the grant is only driven from the first clock edge.
  initial begin
    s_axis = '0;
  end

  // Grant follows the request one cycle later, so it is never withheld.
  always @(posedge pclk) begin
    cfg_gnt <= cfg_req;
  end

  // Sends nb beats, stopping after beat dsc; gap, dsc and fwd name a beat index, or -1 for none.
  task automatic send(input int nb, input logic [3:0] fl, input logic [31:0] hdr, input int gap, input int dsc,
                      input int fwd);
    logic r;
    for (int i = 0; i < nb; i++) begin
      if (i == gap && i > 0) begin
        s_axis.tvalid <= 1'b0;
        s_axis.tdata <= ~s_axis.tdata;
        @(posedge pclk);
      end
      s_axis.tvalid <= 1'b1;
      s_axis.tdata <= {32'hA5A5_0000 + i, 64'h0123_4567_89AB_CDEF, (i == 0) ? hdr : 32'hC0DE_0000 + i};
      s_axis.tkeep <= (i == nb - 1) ? 16'h00FF : 16'hFFFF;
      s_axis.tlast <= (i == nb - 1) || (i == dsc);
      s_axis.tuser <= {(i == dsc) && (i > 0), fl[2], (i == fwd) && !fl[2], fl[0]};
      // Everything is held until ready is seen high at an edge.
      do begin
        @(negedge pclk);
        r = tready;
        @(posedge pclk);
      end while (r !== 1'b1);
      if (i == dsc && i > 0) break;
    end
  endtask : send

  // Releases the stream; stale data is inverted so it cannot pass for a beat.
  task automatic idle();
    s_axis.tvalid <= 1'b0;
    s_axis.tlast <= 1'b0;
    s_axis.tdata <= ~s_axis.tdata;
    s_axis.tuser <= 4'h8;
  endtask : idle
endmodule : ptxf_src_model

// ### bench/tb.sv
/*
  Self-checking bench of the transmit stream flow control block.
  Assumes the block answers APB in one access cycle and holds a pool of four packets.
*/
module tb
  import ptxf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] HDR = 32'h4000_0004;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ptxf_axis_t s_axis;
  logic tready;
  logic tx_err_drop;
  logic tx_cfg_req;
  logic tx_cfg_gnt;
  logic cfg_tlp_pend = 1'b0;
  logic cfg_tlp_done;
  ptxf_lnk_t lnk;
  logic lnk_slot_free = 1'b0;
  logic auto_free = 1'b1;
  logic free_req = 1'b0;
  logic in_pkt = 1'b0;
  logic [31:0] first_hdr = 32'h0000_0000;
  logic [15:0] last_keep = 16'h0000;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_beats, n_last, n_disc, n_null, n_ep, n_drop, n_lo, n_done, n_acc, eof_cyc, drop_cyc;

  ptxf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .s_axis_tx(s_axis),
    .s_axis_tx_tready(tready), .tx_err_drop(tx_err_drop), .tx_cfg_req(tx_cfg_req), .tx_cfg_gnt(tx_cfg_gnt),
    .cfg_tlp_pend(cfg_tlp_pend), .cfg_tlp_done(cfg_tlp_done), .lnk(lnk), .lnk_slot_free(lnk_slot_free));

  ptxf_src_model src (.pclk(pclk), .tready(tready), .cfg_req(tx_cfg_req), .s_axis(s_axis), .cfg_gnt(tx_cfg_gnt));

  // Clock of 50 ns.
  always #25 pclk = ~pclk;

  // Cycle count and release of link slots after each forwarded packet.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    lnk_slot_free <= (auto_free && lnk.valid && lnk.last) || free_req;
  end

  // Observes the block's outputs in mid-cycle, where they are settled.
  always @(negedge pclk) begin
    if (presetn) begin
      if (tready !== 1'b1) n_lo++;
      if (s_axis.tvalid && tready) n_acc++;
      if (s_axis.tvalid && tready && s_axis.tlast) eof_cyc = cyc;
      if (tx_err_drop === 1'b1) begin
        n_drop++;
        drop_cyc = cyc;
      end
      if (cfg_tlp_done === 1'b1) n_done++;
      if (lnk.valid === 1'b1) begin
        n_beats++;
        if (!in_pkt) first_hdr = lnk.data[31:0];
        in_pkt = !lnk.last;
        if (lnk.last === 1'b1) begin
          n_last++;
          n_disc += lnk.discard;
          n_null += lnk.nullify;
          n_ep += lnk.set_ep;
          last_keep = lnk.keep;
        end
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic clr();
    {n_beats, n_last, n_disc, n_null, n_ep, n_drop, n_lo, n_done, n_acc, eof_cyc, drop_cyc} = '0;
  endtask : clr

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  task automatic rdy_is(input logic exp);
    @(negedge pclk);
    chk(tready, exp);
    @(posedge pclk);
  endtask : rdy_is

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    logic r;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      r = pready;
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
    end while (r !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk(err, experr);
  endtask : rd_chk

  // Reset values, read-only capability, stored control and an unmapped offset.
  task automatic t_regs();
    rd_chk(PTXF_OFS_DEVCAP, 32'h0000_0001, 1'b0);
    rd_chk(PTXF_OFS_DEVCTL, 32'h0000_0000, 1'b0);
    rd_chk(PTXF_OFS_POWER_MGMT_CONTROL_STATUS, 32'h0000_0000, 1'b0);
    rd_chk(PTXF_OFS_CTRL, 32'h0000_0001, 1'b0);
    wr(PTXF_OFS_DEVCAP, 32'hFFFF_FFFF);
    wr(PTXF_OFS_DEVCTL, 32'h0000_1234);
    rd_chk(PTXF_OFS_DEVCAP, 32'h0000_0001, 1'b0);
    rd_chk(PTXF_OFS_DEVCTL, 32'h0000_1234, 1'b0);
    rd_chk(8'h20, 32'h0000_0000, 1'b1);
  endtask : t_regs

  // A source stall inside a plain packet; idle cycles carry garbage and discontinue.
  task automatic t_plain();
    clr();
    src.send(3, 4'h0, HDR, 1, -1, -1);
    src.idle();
    wt(6);
    chk(n_beats, 3);
    chk(first_hdr, HDR);
    chk(last_keep, 16'h00FF);
    chk(n_disc + n_null + n_drop, 0);
  endtask : t_plain

  // Digest requested on a packet without one.
  task automatic t_ecrc();
    clr();
    src.send(2, 4'h1, HDR, -1, -1, -1);
    src.idle();
    wt(6);
    chk(n_beats, 3);
    chk(last_keep, 16'h000F);
    chk(first_hdr[PTXF_H_TD], 1'b1);
    chk(n_lo, 1);
  endtask : t_ecrc

  // Error forward raised on a later beat only.
  task automatic t_fwd();
    clr();
    src.send(3, 4'h0, HDR, -1, -1, 1);
    src.idle();
    wt(6);
    chk(n_ep, 1);
    chk(n_disc, 0);
  endtask : t_fwd

  // Source discontinue on the second beat, stored and streamed.
  task automatic t_dsc();
    for (int s = 0; s < 2; s++) begin
      clr();
      src.send(3, {1'b0, s[0], 2'b00}, HDR, -1, 1, -1);
      src.idle();
      wt(6);
      chk(n_disc, (s == 0));
      chk(n_null, (s == 1));
      chk(n_drop, 0);
    end
  endtask : t_dsc

  // Destination discards: link down, oversize payload, streamed stall.
  task automatic t_drop();
    for (int k = 0; k < 3; k++) begin
      clr();
      if (k == 0) wr(PTXF_OFS_CTRL, 32'h0000_0000);
      src.send(2, (k == 2) ? 4'h4 : 4'h0, (k == 1) ? 32'h4000_0064 : HDR, (k == 2) ? 1 : -1, -1, -1);
      src.idle();
      wt(6);
      if (k == 0) wr(PTXF_OFS_CTRL, 32'h0000_0001);
      chk(n_disc, (k != 2));
      chk(n_null, (k == 2));
      chk(n_acc, 2);
      chk(n_drop, 1);
      chk((drop_cyc - eof_cyc >= 1) && (drop_cyc - eof_cyc <= 3), 1);
    end
    rd_chk(PTXF_OFS_STATUS, 32'h0000_0300, 1'b0);
  endtask : t_drop

  // Four back-to-back packets fill the pool while the link holds its slots.
  task automatic t_pool();
    clr();
    auto_free <= 1'b0;
    repeat (4) src.send(1, 4'h0, HDR, -1, -1, -1);
    src.idle();
    rdy_is(1'b0);
    wt(4);
    rdy_is(1'b0);
    chk(n_acc, 4);
    free_req <= 1'b1;
    wt(4);
    free_req <= 1'b0;
    auto_free <= 1'b1;
    wt(2);
    rdy_is(1'b1);
  endtask : t_pool

  // Power state leaves D0 in mid-packet.
  task automatic t_pm();
    clr();
    fork
      src.send(6, 4'h0, HDR, -1, -1, -1);
      begin
        wt(1);
        wr(PTXF_OFS_POWER_MGMT_CONTROL_STATUS, 32'h0000_0003);
      end
    join
    src.idle();
    chk(n_acc, 6);
    clr();
    wt(10);
    chk(n_lo, 10);
    wr(PTXF_OFS_POWER_MGMT_CONTROL_STATUS, 32'h0000_0000);
    wt(2);
    rdy_is(1'b1);
  endtask : t_pm

  // An internal packet is requested, granted and sent.
  task automatic t_cfg();
    clr();
    cfg_tlp_pend <= 1'b1;
    @(negedge pclk);
    @(negedge pclk);
    chk(tx_cfg_req, 1'b1);
    for (int i = 0; i < 40 && n_done == 0; i++) @(posedge pclk);
    cfg_tlp_pend <= 1'b0;
    wt(6);
    chk(n_done, 1);
    // Grant cycle, four slot cycles and the done cycle keep ready low.
    chk(n_lo, 6);
  endtask : t_cfg

  // Main sequence.
  initial begin
    clr();
    wt(2);
    presetn <= 1'b1;
    wt(2);
    t_regs();
    t_plain();
    t_ecrc();
    t_fwd();
    t_dsc();
    t_drop();
    t_pool();
    t_pm();
    t_cfg();
    test_done();
  end

  // Cuts a hang short.
  initial begin
    #(50ns * 4000);
    errors++;
    test_done();
  end
endmodule : tb
